// file: isp_security_autobaud.v
/*
 serial programming front end: autobaud and echo, hex record parser,
 security byte gating and one character or two hex digit replies, axi4-lite slave.
 assumes rxd synchronous to aclk and a well behaved axi4-lite master.
*/
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "isp_defines.vh"

module isp_security_autobaud (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rxd,
  output reg         txd,
  output reg         session_open,
  output reg         flash_program_strobe,
  output reg         block_erase_strobe,
  output reg         chip_erase_strobe
);

  localparam AB_WAIT  = 2'd0;
  localparam AB_MEAS  = 2'd1;
  localparam AB_REST  = 2'd2;
  localparam AB_OPEN  = 2'd3;
  localparam W = `BIT_CNT_W;

  reg  [7:0]   security_level_byte;
  reg  [7:0]   boot_status_byte;
  reg  [7:0]   soft_boot_vector;
  reg  [1:0]   ab_state;
  reg  [W-1:0] bit_cycles;
  reg  [W-1:0] ab_cnt;
  reg  [3:0]   ab_bits;
  reg          rxd_d;
  reg          rx_busy;
  reg  [W-1:0] rx_tmr;
  reg  [3:0]   rx_bitn;
  reg  [7:0]   rx_shift;
  reg          rx_done;
  reg  [7:0]   rx_byte;
  reg          in_rec;
  reg          nib_hi;
  reg  [3:0]   hi_nib;
  reg  [7:0]   idx;
  reg  [7:0]   rec_len;
  reg  [7:0]   rec_type;
  reg  [7:0]   d0;
  reg  [7:0]   d1;
  reg  [7:0]   d2;
  reg  [7:0]   sum;
  reg          rec_end;
  reg  [7:0]   q0;
  reg  [7:0]   q1;
  reg  [7:0]   q2;
  reg  [7:0]   q3;
  reg  [2:0]   q_cnt;
  reg          tx_busy;
  reg  [9:0]   tx_shift;
  reg  [3:0]   tx_bitn;
  reg  [W-1:0] tx_tmr;
  reg          echo_u;
  reg  [3:0]   aw_addr;
  reg          aw_full;
  reg  [31:0]  w_data;
  reg          w_full;
  reg          ctl_erase;
  reg          ctl_rebaud;

  function is_hex;
    input [7:0] c;
    is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46)
             || (c >= 8'h61 && c <= 8'h66);
  endfunction

  function [3:0] hex_val;
    input [7:0] c;
    if (c <= 8'h39)
      hex_val = c[3:0];
    else
      hex_val = c[3:0] + 4'h9;
  endfunction

  function [7:0] hex_chr;
    input [3:0] n;
    hex_chr = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
  endfunction

  // level 0/1/2 from the byte; unknown codes treated as level 2
  wire [1:0] lvl = (security_level_byte == `SEC_LEVEL0) ? 2'd0 :
                   (security_level_byte == `SEC_LEVEL1) ? 2'd1 :
                   2'd2;
  wire [7:0] deny_char = (lvl == 2'd2) ? `CH_L : `CH_P;

  // ----------------------------------------------------------------
  // record execution: reply and effects
  // ----------------------------------------------------------------
  reg [7:0] rep0;
  reg [7:0] rep1;
  reg [2:0] rep_n;
  reg       do_prog;
  reg       do_blk;
  reg       do_chip;
  reg       do_boot_erase;
  reg       do_bsb;
  reg       do_sbv;
  reg       do_sec;
  reg [7:0] sec_new;
  reg [7:0] rd_val;

  always @* begin
    rep0 = `CH_OK;
    rep1 = `CH_CR;
    rep_n = 3'd3;
    do_prog = 1'b0;
    do_blk = 1'b0;
    do_chip = 1'b0;
    do_boot_erase = 1'b0;
    do_bsb = 1'b0;
    do_sbv = 1'b0;
    do_sec = 1'b0;
    sec_new = (d1 == 8'h00) ? `SEC_LEVEL1 : `SEC_LEVEL2;
    rd_val = security_level_byte;
    if (sum != 8'h00) begin
      rep0 = `CH_X;
    end else if (rec_type == `REC_PROGRAM) begin
      if (lvl != 2'd0)
        rep0 = deny_char;
      else
        do_prog = 1'b1;
    end else if (rec_type == `REC_WRITE_FN) begin
      case (d0)
        `FN_CHIP_ERASE: do_chip = 1'b1;
        `FN_SECURITY: begin
          if (lvl == 2'd2)
            rep0 = `CH_L;
          else if ((sec_new == `SEC_LEVEL2) || (lvl == 2'd0))
            do_sec = 1'b1;
          else
            rep0 = `CH_P;
        end
        `FN_BLOCK_ERASE: begin
          if (lvl != 2'd0)
            rep0 = deny_char;
          else
            do_blk = 1'b1;
        end
        `FN_ERASE_BOOT, `FN_BOOT_BYTES: begin
          if (lvl != 2'd0)
            rep0 = deny_char;
          else if (d0 == `FN_ERASE_BOOT)
            do_boot_erase = 1'b1;
          else begin
            do_bsb = (d1 == 8'h00);
            do_sbv = (d1 == 8'h01);
          end
        end
        default: rep0 = `CH_OK;
      endcase
    end else if (rec_type == `REC_READ_FN) begin
      if (d0 == `FN_READ_BOOT && d1 == 8'h00) begin
        rep_n = 3'd4;
      end else if (lvl == 2'd2) begin
        rep0 = `CH_L;
      end else if (d0 == `FN_READ_BOOT) begin
        rep_n = 3'd4;
        rd_val = (d1 == 8'h01) ? boot_status_byte : soft_boot_vector;
      end
    end
    if (rep_n == 3'd4) begin
      rep0 = hex_chr(rd_val[7:4]);
      rep1 = hex_chr(rd_val[3:0]);
    end
  end

  // ----------------------------------------------------------------
  // security state and boot bytes
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      security_level_byte <= `SEC_LEVEL0;
      boot_status_byte <= `BSB_DEFAULT;
      soft_boot_vector <= `SBV_DEFAULT;
      flash_program_strobe <= 1'b0;
      block_erase_strobe <= 1'b0;
      chip_erase_strobe <= 1'b0;
    end else begin
      flash_program_strobe <= rec_end & do_prog;
      block_erase_strobe <= rec_end & do_blk;
      // user flash only; the boot program is outside this strobe
      chip_erase_strobe <= (rec_end & do_chip) | ctl_erase;
      if ((rec_end & do_chip) | ctl_erase) begin
        boot_status_byte <= `BSB_DEFAULT;
        soft_boot_vector <= `SBV_DEFAULT;
        security_level_byte <= `SEC_LEVEL0;
      end else if (rec_end) begin
        if (do_sec)
          security_level_byte <= sec_new;
        if (do_boot_erase | do_bsb)
          boot_status_byte <= do_bsb ? d2 : `BSB_DEFAULT;
        if (do_boot_erase | do_sbv)
          soft_boot_vector <= do_sbv ? d2 : `SBV_DEFAULT;
      end
    end
  end

  // ----------------------------------------------------------------
  // autobaud: low time of the start bit of U is one bit
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      ab_state <= AB_WAIT;
      bit_cycles <= {W{1'b1}};
      ab_cnt <= {W{1'b0}};
      ab_bits <= 4'h0;
      rxd_d <= 1'b1;
      echo_u <= 1'b0;
      session_open <= 1'b0;
    end else begin
      rxd_d <= rxd;
      echo_u <= 1'b0;
      case (ab_state)
        AB_WAIT: begin
          ab_cnt <= {{(W-1){1'b0}}, 1'b1};
          if (rxd_d & ~rxd)
            ab_state <= AB_MEAS;
        end
        AB_MEAS: begin
          ab_cnt <= ab_cnt + 1'b1;
          if (rxd) begin
            bit_cycles <= ab_cnt;
            ab_cnt <= {W{1'b0}};
            ab_bits <= 4'h0;
            ab_state <= AB_REST;
          end
        end
        AB_REST: begin
          ab_cnt <= ab_cnt + 1'b1;
          if (ab_cnt == bit_cycles - 1'b1) begin
            ab_cnt <= {W{1'b0}};
            ab_bits <= ab_bits + 1'b1;
            if (ab_bits == `CHAR_REST_BITS - 4'h1) begin
              echo_u <= 1'b1;
              session_open <= 1'b1;
              ab_state <= AB_OPEN;
            end
          end
        end
        AB_OPEN: begin
          if (ctl_rebaud) begin
            session_open <= 1'b0;
            ab_state <= AB_WAIT;
          end
        end
        default: ab_state <= AB_WAIT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receiver and record parser
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_busy <= 1'b0;
      rx_tmr <= {W{1'b0}};
      rx_bitn <= 4'h0;
      rx_shift <= 8'h00;
      rx_done <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        rx_tmr <= {1'b0, bit_cycles[W-1:1]};
        rx_bitn <= 4'h0;
        if (session_open & rxd_d & ~rxd)
          rx_busy <= 1'b1;
      end else if (rx_tmr != {W{1'b0}}) begin
        rx_tmr <= rx_tmr - 1'b1;
      end else begin
        rx_tmr <= bit_cycles - 1'b1;
        rx_bitn <= rx_bitn + 1'b1;
        if (rx_bitn == 4'h0) begin
          rx_busy <= ~rxd;
        end else if (rx_bitn == 4'h9) begin
          rx_busy <= 1'b0;
          rx_done <= rxd;
          rx_byte <= rx_shift;
        end else begin
          rx_shift <= {rxd, rx_shift[7:1]};
        end
      end
    end
  end

  wire [7:0] byte_val = {hi_nib, hex_val(rx_byte)};

  always @(posedge aclk) begin
    if (!aresetn) begin
      in_rec <= 1'b0;
      nib_hi <= 1'b1;
      hi_nib <= 4'h0;
      idx <= 8'h00;
      rec_len <= 8'h00;
      rec_type <= 8'h00;
      d0 <= 8'h00;
      d1 <= 8'h00;
      d2 <= 8'h00;
      sum <= 8'h00;
      rec_end <= 1'b0;
    end else begin
      rec_end <= 1'b0;
      if (rx_done) begin
        if (rx_byte == `CH_COLON) begin
          in_rec <= 1'b1;
          nib_hi <= 1'b1;
          idx <= 8'h00;
          sum <= 8'h00;
        end else if (!in_rec || !is_hex(rx_byte)) begin
          in_rec <= 1'b0;
        end else if (nib_hi) begin
          hi_nib <= hex_val(rx_byte);
          nib_hi <= 1'b0;
        end else begin
          nib_hi <= 1'b1;
          idx <= idx + 1'b1;
          sum <= sum + byte_val;
          if (idx == 8'h00)
            rec_len <= byte_val;
          if (idx == 8'h03)
            rec_type <= byte_val;
          if (idx == 8'h04)
            d0 <= byte_val;
          if (idx == 8'h05)
            d1 <= byte_val;
          if (idx == 8'h06)
            d2 <= byte_val;
          if (idx == rec_len + 8'h04) begin
            in_rec <= 1'b0;
            rec_end <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // reply queue and transmitter
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      q0 <= 8'h00;
      q1 <= 8'h00;
      q2 <= 8'h00;
      q3 <= 8'h00;
      q_cnt <= 3'd0;
      tx_busy <= 1'b0;
      tx_shift <= 10'h3FF;
      tx_bitn <= 4'h0;
      tx_tmr <= {W{1'b0}};
      txd <= 1'b1;
    end else begin
      if (echo_u) begin
        q0 <= `CH_U;
        q_cnt <= 3'd1;
      end else if (rec_end) begin
        q0 <= rep0;
        q1 <= (rep_n == 3'd4) ? rep1 : `CH_CR;
        q2 <= (rep_n == 3'd4) ? `CH_CR : `CH_LF;
        q3 <= `CH_LF;
        q_cnt <= rep_n;
      end else if (!tx_busy && q_cnt != 3'd0) begin
        q0 <= q1;
        q1 <= q2;
        q2 <= q3;
        q_cnt <= q_cnt - 1'b1;
      end
      if (!tx_busy) begin
        txd <= 1'b1;
        if (q_cnt != 3'd0 && !echo_u && !rec_end) begin
          tx_busy <= 1'b1;
          tx_shift <= {1'b1, q0, 1'b0};
          tx_bitn <= 4'h0;
          tx_tmr <= {W{1'b0}};
        end
      end else if (tx_tmr != {W{1'b0}}) begin
        tx_tmr <= tx_tmr - 1'b1;
      end else begin
        txd <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_tmr <= bit_cycles - 1'b1;
        tx_bitn <= tx_bitn + 1'b1;
        if (tx_bitn == 4'hA)
          tx_busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
      aw_addr <= 4'h0;
      aw_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_full <= 1'b0;
      ctl_erase <= 1'b0;
      ctl_rebaud <= 1'b0;
    end else begin
      ctl_erase <= 1'b0;
      ctl_rebaud <= 1'b0;
      s_axi_awready <= ~aw_full & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_full & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_full & w_full & ~s_axi_bvalid) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == `OFS_CONTROL) ? 2'b00 : 2'b10;
        if (aw_addr == `OFS_CONTROL) begin
          ctl_erase <= w_data[0];
          ctl_rebaud <= w_data[1];
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `OFS_STATUS: s_axi_rdata <= {20'h0_0000, 1'b0, session_open,
                                       lvl, security_level_byte};
          `OFS_BOOT_BYTES: s_axi_rdata <= {16'h0000, soft_boot_vector,
                                           boot_status_byte};
          `OFS_CONTROL: s_axi_rdata <= 32'h0000_0000;
          `OFS_BIT_TIME: s_axi_rdata <= {{(32-W){1'b0}}, bit_cycles};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // isp_security_autobaud

// file: isp_defines.vh
/*
 constants for the serial programming front end: register offsets,
 security byte codes, reset values, characters and record codes.
 assumes inclusion by bare name from the design file.
*/
`ifndef ISP_DEFINES_VH
`define ISP_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_STATUS      4'h0
`define OFS_BOOT_BYTES  4'h4
`define OFS_CONTROL     4'h8
`define OFS_BIT_TIME    4'hC

// ----------------------------------------------------------------
// security byte codes and reset values
// ----------------------------------------------------------------
`define SEC_LEVEL0      8'hFF
`define SEC_LEVEL1      8'hFE
`define SEC_LEVEL2      8'hFC
`define BSB_DEFAULT     8'hFF
`define SBV_DEFAULT     8'hFC

// ----------------------------------------------------------------
// characters
// ----------------------------------------------------------------
`define CH_U            8'h55
`define CH_P            8'h50
`define CH_L            8'h4C
`define CH_X            8'h58
`define CH_OK           8'h2E
`define CH_COLON        8'h3A
`define CH_CR           8'h0D
`define CH_LF           8'h0A

// ----------------------------------------------------------------
// record types and write- and read-function selectors
// ----------------------------------------------------------------
`define REC_PROGRAM     8'h00
`define REC_WRITE_FN    8'h03
`define REC_BLANK       8'h04
`define REC_READ_FN     8'h05
`define FN_BLOCK_ERASE  8'h01
`define FN_ERASE_BOOT   8'h04
`define FN_SECURITY     8'h05
`define FN_BOOT_BYTES   8'h06
`define FN_CHIP_ERASE   8'h07
`define FN_READ_BOOT    8'h07

// ----------------------------------------------------------------
// timing: character length in bit times after the measured bit
// ----------------------------------------------------------------
`define CHAR_REST_BITS  4'h9
`define BIT_CNT_W       20

`endif

// file: host_link.sv
/*
 host side model of the serial link: sends framed bytes on rxd and
 collects the bytes seen on txd. assumes 8N1 at a fixed bit time in
 aclk cycles, with the caller just after a rising edge.
*/
`timescale 1ns/1ps
module host_link #(
  parameter int BIT = 16
) (
  input  wire  aclk,
  input  wire  txd,
  output logic rxd
);
  logic [7:0] rx_q[$];
  logic [7:0] d;

  initial rxd = 1'b1;

  // ----------------------------------------------------------------
  // transmit: start, eight data bits lsb first, stop
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= fr[i];
      repeat (BIT) @(posedge aclk);
    end
  endtask

  // ----------------------------------------------------------------
  // receive: sample mid bit, queue each byte
  // ----------------------------------------------------------------
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge aclk);
    for (int j = 0; j < 8; j++) begin
      repeat (BIT) @(posedge aclk);
      d[j] = txd;
    end
    repeat (BIT) @(posedge aclk);
    rx_q.push_back(d);
  end
endmodule // host_link

// file: isp_security_autobaud_chk.sv
/*
 port assertions for the serial programming front end.
 assumes one aclk domain with synchronous active low aresetn.
*/
`timescale 1ns/1ps
module isp_security_autobaud_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire [3:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [3:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        txd,
  input wire        session_open,
  input wire        flash_program_strobe,
  input wire        chip_erase_strobe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> txd && !session_open && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs busy after reset");
  a_idle_closed: assert property (!session_open |-> txd)
    else $error("txd active before session");
  a_start_bit: assert property ($fell(txd) |-> !txd [*8])
    else $error("start bit too short");
  a_erase_pulse: assert property (chip_erase_strobe |=> !chip_erase_strobe)
    else $error("chip erase strobe not a pulse");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer late");
  a_ctrl_reads0: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == 4'h8 |=> s_axi_rdata == 32'h0 && s_axi_rresp == 2'b00)
    else $error("control read not zero");
  a_ctrl_okay: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_awaddr == 4'h8 |-> ##[1:4] s_axi_bvalid && s_axi_bresp == 2'b00)
    else $error("control write not okay");
  a_other_slverr: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_awaddr != 4'h8 |-> ##[1:4] s_axi_bvalid && s_axi_bresp == 2'b10)
    else $error("read only write not refused");

  c_open: cover property ($rose(session_open));
  c_erase: cover property (chip_erase_strobe);
  c_prog: cover property (flash_program_strobe);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // isp_security_autobaud_chk

bind isp_security_autobaud isp_security_autobaud_chk i_chk (.*);

// file: isp_security_autobaud_bench.sv
/*
 self-checking bench for the serial programming front end.
 assumes the host_link model on the serial pins and the bound checker.
*/
`timescale 1ns/1ps
module isp_security_autobaud_bench;
  localparam int BIT = 16;
  localparam string OK = ".\015\012";
  localparam string PR = "P\015\012";
  localparam string LK = "L\015\012";
  localparam string XR = "X\015\012";
  localparam string RD_FF = "FF\015\012";
  localparam string RD_FC = "FC\015\012";
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0;
  logic [3:0]  s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid, txd, rxd, session_open;
  wire         flash_program_strobe, block_erase_strobe, chip_erase_strobe;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          prog_cnt = 0;
  int          blk_cnt = 0;
  int          chip_cnt = 0;
  int          e_prog = 0;
  logic [31:0] seed = 32'h4606_00ca;
  logic [31:0] d;
  logic [1:0]  r;
  logic [7:0]  rec[$];

  always #2.5 aclk = ~aclk;

  // count the one-cycle flash strobes
  always @(posedge aclk) begin
    if (flash_program_strobe === 1'b1) prog_cnt <= prog_cnt + 1;
    if (block_erase_strobe === 1'b1) blk_cnt <= blk_cnt + 1;
    if (chip_erase_strobe === 1'b1) chip_cnt <= chip_cnt + 1;
  end

  isp_security_autobaud i_dut (.*);
  host_link #(.BIT(BIT)) lnk (.aclk(aclk), .txd(txd), .rxd(rxd));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 10) ? 8'h30 + n : 8'h37 + n;
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk("write latency", 1, n <= 4);
  endtask

  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", 2'b00, s_axi_rresp);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    axi_rd(a);
    chk("rdata", e, d);
  endtask

  task automatic expect_txt(input string s);
    int n;
    for (int i = 0; i < s.len(); i++) begin
      n = 0;
      while (lnk.rx_q.size() == 0 && n < 5000) begin
        @(posedge aclk);
        n++;
      end
      chk("reply", s[i], lnk.rx_q.size() ? lnk.rx_q.pop_front() : 8'hxx);
    end
  endtask

  // record: colon, hex pairs, checksum (spoilt by one when bad)
  task automatic cmd(input logic [7:0] b[$], input bit bad, input string s);
    logic [7:0] sum;
    sum = 8'h00;
    lnk.send(8'h3a);
    foreach (b[i]) begin
      lnk.send(hexc(b[i][7:4]));
      lnk.send(hexc(b[i][3:0]));
      sum += b[i];
    end
    sum = 8'h00 - sum + {7'h0, bad};
    lnk.send(hexc(sum[7:4]));
    lnk.send(hexc(sum[3:0]));
    expect_txt(s);
  endtask

  task results();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(4'h0, 32'h0000_00ff);
    rd_chk(4'h4, 32'h0000_fcff);
    axi_wr(4'h0, 32'h0000_0001);
    chk("bresp", 2'b10, r);
    rd_chk(4'h8, 32'h0000_0000);
    lnk.send(8'h55);
    expect_txt("U");
    rd_chk(4'h0, 32'h0000_04ff);
    axi_rd(4'hc);
    chk("bit time", 1, d >= BIT - 1 && d <= BIT + 1);
    cmd('{8'h02, 8'h00, 8'h00, 8'h03, 8'h05, 8'h00}, 1'b1, XR);
    rd_chk(4'h0, 32'h0000_04ff);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      rec = '{8'h01, seed[15:8], seed[23:16], 8'h00, seed[7:0]};
      cmd(rec, seed[24], seed[24] ? XR : OK);
      if (!seed[24]) e_prog++;
    end
    cmd('{8'h02, 8'h00, 8'h00, 8'h03, 8'h01, 8'h00}, 1'b0, OK);
    cmd('{8'h02, 8'h00, 8'h00, 8'h05, 8'h07, 8'h00}, 1'b0, RD_FF);
    cmd('{8'h03, 8'h00, 8'h00, 8'h03, 8'h06, 8'h01, 8'h33}, 1'b0, OK);
    rd_chk(4'h4, 32'h0000_33ff);
    cmd('{8'h02, 8'h00, 8'h00, 8'h03, 8'h04, 8'h00}, 1'b0, OK);
    rd_chk(4'h4, 32'h0000_fcff);
    cmd('{8'h02, 8'h00, 8'h00, 8'h03, 8'h05, 8'h00}, 1'b0, OK);
    rd_chk(4'h0, 32'h0000_05fe);
    cmd('{8'h02, 8'h00, 8'h00, 8'h03, 8'h01, 8'h00}, 1'b0, PR);
    cmd('{8'h02, 8'h00, 8'h00, 8'h05, 8'h07, 8'h02}, 1'b0, RD_FC);
    cmd('{8'h03, 8'h00, 8'h00, 8'h03, 8'h06, 8'h00, 8'h55}, 1'b0, PR);
    cmd('{8'h01, 8'h00, 8'h10, 8'h00, 8'h55}, 1'b0, PR);
    rd_chk(4'h4, 32'h0000_fcff);
    cmd('{8'h02, 8'h00, 8'h00, 8'h03, 8'h05, 8'h00}, 1'b0, PR);
    cmd('{8'h02, 8'h00, 8'h00, 8'h03, 8'h05, 8'h01}, 1'b0, OK);
    rd_chk(4'h0, 32'h0000_06fc);
    cmd('{8'h02, 8'h00, 8'h00, 8'h05, 8'h07, 8'h01}, 1'b0, LK);
    cmd('{8'h02, 8'h00, 8'h00, 8'h05, 8'h07, 8'h00}, 1'b0, RD_FC);
    cmd('{8'h01, 8'h00, 8'h10, 8'h00, 8'h55}, 1'b0, LK);
    cmd('{8'h02, 8'h00, 8'h00, 8'h03, 8'h05, 8'h00}, 1'b0, LK);
    rd_chk(4'h0, 32'h0000_06fc);
    cmd('{8'h01, 8'h00, 8'h00, 8'h03, 8'h07}, 1'b0, OK);
    rd_chk(4'h0, 32'h0000_04ff);
    cmd('{8'h03, 8'h00, 8'h00, 8'h03, 8'h06, 8'h00, 8'h55}, 1'b0, OK);
    rd_chk(4'h4, 32'h0000_fc55);
    cmd('{8'h02, 8'h00, 8'h00, 8'h03, 8'h05, 8'h01}, 1'b0, OK);
    axi_wr(4'h8, 32'h0000_0001);
    chk("bresp", 2'b00, r);
    rd_chk(4'h0, 32'h0000_04ff);
    rd_chk(4'h4, 32'h0000_fcff);
    axi_wr(4'h8, 32'h0000_0002);
    rd_chk(4'h0, 32'h0000_00ff);
    lnk.send(8'h55);
    expect_txt("U");
    rd_chk(4'h0, 32'h0000_04ff);
    chk("program strobes", e_prog, prog_cnt);
    chk("block erase strobes", 1, blk_cnt);
    chk("chip erase strobes", 2, chip_cnt);
    results();
  end

  // cut a hang short
  initial begin
    repeat (95000) @(posedge aclk);
    error_cnt++;
    results();
  end
endmodule // isp_security_autobaud_bench
